// ### logic/adc_trig_map.vh
// Register map and field constants for the converter trigger and compare control
`ifndef ADC_TRIG_MAP_VH
`define ADC_TRIG_MAP_VH
`define ADDR_CTRL_ONE    8'he1
`define ADDR_CTRL_TWO    8'he2
`define ADDR_DELAY_LOW   8'he3
`define ADDR_CTRL_ZERO   8'he8
`define ADDR_THRESH_LOW  8'he4
`define ADDR_THRESH_HIGH 8'he5
`define ADDR_INT_STATUS  8'he6
`define ADDR_INT_MASK    8'he7
`define BYTE_ZERO        8'h00
`define THRESH_ZERO      12'h000
`define TYPE_FALL        2'h0
`define TYPE_RISE        2'h1
`define TYPE_CENTRE      2'h2
`define TYPE_END         2'h3
`define SRC_PWM_CHANNEL_ZERO         2'h0
`define SRC_PWM_CHANNEL_TWO         2'h1
`define SRC_PWM_CHANNEL_FOUR         2'h2
`define SRC_PIN          2'h3
`define DELAY_ZERO       9'h000
`define DELAY_ONE        9'h001
`define CONV_CYCLES      5'h10
`define CONV_ZERO        5'h00
`define CONV_ONE         5'h01
`endif

// ### logic/edge_sync.v
// Three-stage synchroniser with agreement-based edge detection
`timescale 1ns/10ps
module edge_sync (
  // Clock and reset
  input  wire mclk,
  input  wire srst,
  // Asynchronous input and detected events
  input  wire din,
  output reg  level_reg,
  output reg  rise_reg,
  output reg  fall_reg
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // Level changes once stages two and three agree
  always @(posedge mclk) begin
    if (srst) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_reg <= 1'b0;
      rise_reg  <= 1'b0;
      fall_reg  <= 1'b0;
    end else begin
      s1_reg    <= din;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      rise_reg  <= 1'b0;
      fall_reg  <= 1'b0;
      if (s2_reg == s3_reg && s3_reg != level_reg) begin
        level_reg <= s3_reg;
        rise_reg  <= s3_reg;
        fall_reg  <= ~s3_reg;
      end
    end
  end
endmodule // edge_sync

// ### logic/adc_trigger_compare_ctrl.v
// Converter trigger selection, trigger delay, result compare and fault brake
// Summary of operation
// - Trigger type: fall, rise, centre, end
// - Centre/end triggers only in centre-aligned mode
// - External disabled: only software start converts
// - External enabled: software or selected source
// - Triggers dropped while conversion busy
// - Converter enable bit switches converter
// - Compare output with brake: brake, clear run
// - Polarity picks ge or less-than compare
// - Comparator works only when enabled
// - Compare flag read-only, refreshed per conversion
// - Delay: low byte plus control bit
// - Wait delay count before starting
// - Delay only for external triggers
// - Source select: PWM_CHANNEL_ZERO, PWM_CHANNEL_TWO, PWM_CHANNEL_FOUR, pin
// - Start bit reads busy, self clears
// - Done flag blocks new conversions
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`include "adc_trig_map.vh"
module adc_trigger_compare_ctrl (
  // Clock and reset
  input  wire        mclk,
  input  wire        srst,
  // Register port
  input  wire [7:0]  addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [7:0]  rdata_reg,
  // Trigger sources
  input  wire        pwm_channel_zero,
  input  wire        pwm_channel_two,
  input  wire        pwm_channel_four,
  input  wire        ext_start_pin,
  input  wire        pwm_centre_aligned,
  input  wire        pwm_period_centre,
  input  wire        pwm_period_end,
  // Converter interface
  input  wire [11:0] conversion_result,
  input  wire        conv_complete,
  output reg         converter_on_reg,
  output reg         conv_start_reg,
  // PWM brake
  output reg         fault_brake_reg,
  output reg         pwm_run_clear_reg,
  // Interrupt
  output reg         irq_reg
);
  // Control fields
  reg        converter_on;
  reg        ext_trigger_enable;
  reg [1:0]  ext_trigger_type;
  reg [1:0]  ext_trigger_source;
  reg        compare_brake_enable;
  reg        compare_polarity;
  reg        comparator_enable;
  reg        compare_result_flag;
  reg [8:0]  trigger_delay_count;
  reg [11:0] compare_threshold;
  reg        conversion_done_flag;
  // Sequencing state
  reg        busy_reg;
  reg        delay_active_reg;
  reg [8:0]  delay_cnt_reg;
  reg [4:0]  conv_cnt_reg;
  // Interrupt state
  reg [1:0]  int_status_reg;
  reg [1:0]  int_mask_reg;
  // Period event history
  reg        pc_sync_reg;
  reg        pe_sync_reg;
  reg        pc_prev_reg;
  reg        pe_prev_reg;

  // Synchroniser outputs and decode
  wire [3:0] src_level;
  wire [3:0] src_rise;
  wire [3:0] src_fall;
  wire [3:0] src_raw;
  reg        ext_event;
  reg        sel_rise;
  reg        sel_fall;
  wire       sw_start;
  wire       can_start;
  wire       cmp_out;

  assign src_raw = {ext_start_pin, pwm_channel_four, pwm_channel_two, pwm_channel_zero};

  // One synchroniser per candidate source
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      edge_sync u_sync (
        .mclk      (mclk),
        .srst      (srst),
        .din       (src_raw[gi]),
        .level_reg (src_level[gi]),
        .rise_reg  (src_rise[gi]),
        .fall_reg  (src_fall[gi])
      );
    end
  endgenerate

  // Compare function used for result evaluation
  // Polarity selects at-or-above or strictly below
  function cmp_fn;
    input [11:0] res;
    input [11:0] thr;
    input        pol;
    begin
      cmp_fn = pol ? (res < thr) : (res >= thr);
    end
  endfunction

  // Trigger source and type decode
  always @* begin
    sel_rise = 1'b0;
    sel_fall = 1'b0;
    case (ext_trigger_source)
      `SRC_PWM_CHANNEL_ZERO: begin
        sel_rise = src_rise[0];
        sel_fall = src_fall[0];
      end
      `SRC_PWM_CHANNEL_TWO: begin
        sel_rise = src_rise[1];
        sel_fall = src_fall[1];
      end
      `SRC_PWM_CHANNEL_FOUR: begin
        sel_rise = src_rise[2];
        sel_fall = src_fall[2];
      end
      default: begin
        sel_rise = src_rise[3];
        sel_fall = src_fall[3];
      end
    endcase
    case (ext_trigger_type)
      `TYPE_FALL:   ext_event = sel_fall;
      `TYPE_RISE:   ext_event = sel_rise;
      `TYPE_CENTRE: ext_event = pwm_centre_aligned & pc_sync_reg & ~pc_prev_reg;
      `TYPE_END:    ext_event = pwm_centre_aligned & pe_sync_reg & ~pe_prev_reg;
      default:      ext_event = 1'b0;
    endcase
  end

  // Start request, start permission and compare value
  // Delay phase also blocks new events, so one edge gives one start
  assign sw_start  = wr && (addr == `ADDR_CTRL_ZERO) && wdata[6];
  assign can_start = converter_on && !busy_reg && !conversion_done_flag;
  assign cmp_out   = cmp_fn(conversion_result, compare_threshold, compare_polarity);

  // Period event edge detection (same clock domain)
  always @(posedge mclk) begin
    if (srst) begin
      pc_sync_reg <= 1'b0;
      pe_sync_reg <= 1'b0;
      pc_prev_reg <= 1'b0;
      pe_prev_reg <= 1'b0;
    end else begin
      pc_sync_reg <= pwm_period_centre;
      pe_sync_reg <= pwm_period_end;
      pc_prev_reg <= pc_sync_reg;
      pe_prev_reg <= pe_sync_reg;
    end
  end

  // Register writes, trigger delay, conversion sequencing and compare
  always @(posedge mclk) begin
    if (srst) begin
      converter_on         <= 1'b0;
      ext_trigger_enable   <= 1'b0;
      ext_trigger_type     <= `TYPE_FALL;
      ext_trigger_source   <= `SRC_PWM_CHANNEL_ZERO;
      compare_brake_enable <= 1'b0;
      compare_polarity     <= 1'b0;
      comparator_enable    <= 1'b0;
      compare_result_flag  <= 1'b0;
      trigger_delay_count  <= `DELAY_ZERO;
      compare_threshold    <= `THRESH_ZERO;
      conversion_done_flag <= 1'b0;
      busy_reg             <= 1'b0;
      delay_active_reg     <= 1'b0;
      delay_cnt_reg        <= `DELAY_ZERO;
      conv_cnt_reg         <= `CONV_ZERO;
      int_status_reg       <= 2'h0;
      int_mask_reg         <= 2'h0;
      conv_start_reg       <= 1'b0;
      fault_brake_reg      <= 1'b0;
      pwm_run_clear_reg    <= 1'b0;
      converter_on_reg     <= 1'b0;
      irq_reg              <= 1'b0;
      rdata_reg            <= `BYTE_ZERO;
    end else begin
      conv_start_reg    <= 1'b0;
      pwm_run_clear_reg <= 1'b0;
      converter_on_reg  <= converter_on;
      // Software writes
      if (wr) begin
        case (addr)
          `ADDR_CTRL_ONE: begin
            ext_trigger_type   <= wdata[3:2];
            ext_trigger_enable <= wdata[1];
            converter_on       <= wdata[0];
          end
          `ADDR_CTRL_TWO: begin
            compare_brake_enable   <= wdata[7];
            compare_polarity       <= wdata[6];
            comparator_enable      <= wdata[5];
            trigger_delay_count[8] <= wdata[0];
          end
          `ADDR_DELAY_LOW:   trigger_delay_count[7:0] <= wdata;
          `ADDR_CTRL_ZERO: begin
            ext_trigger_source <= wdata[5:4];
            // Done flag: writing zero clears it, one keeps it
            if (!wdata[7])
              conversion_done_flag <= 1'b0;
          end
          `ADDR_THRESH_LOW:  compare_threshold[7:0]  <= wdata;
          `ADDR_THRESH_HIGH: compare_threshold[11:8] <= wdata[3:0];
          `ADDR_INT_MASK:    int_mask_reg <= wdata[1:0];
          default: ;
        endcase
      end
      // Start paths: software immediate, external after delay
      // Software start cancels a pending delayed trigger
      if (sw_start && can_start) begin
        busy_reg         <= 1'b1;
        delay_active_reg <= 1'b0;
        conv_cnt_reg     <= `CONV_CYCLES;
        conv_start_reg   <= 1'b1;
      end else if (delay_active_reg) begin
        if (delay_cnt_reg == `DELAY_ZERO || !ext_trigger_enable) begin
          delay_active_reg <= 1'b0;
          if (ext_trigger_enable && can_start) begin
            busy_reg       <= 1'b1;
            conv_cnt_reg   <= `CONV_CYCLES;
            conv_start_reg <= 1'b1;
          end
        end else begin
          delay_cnt_reg <= delay_cnt_reg - `DELAY_ONE;
        end
      end else if (ext_trigger_enable && ext_event && can_start) begin
        delay_active_reg <= 1'b1;
        delay_cnt_reg    <= trigger_delay_count;
      end
      // Busy period; external events ignored meanwhile
      if (busy_reg) begin
        if (conv_complete || conv_cnt_reg == `CONV_ONE) begin
          busy_reg             <= 1'b0;
          conv_cnt_reg         <= `CONV_ZERO;
          conversion_done_flag <= 1'b1;
          int_status_reg[0]    <= 1'b1;
          if (comparator_enable) begin
            compare_result_flag <= cmp_out;
            if (cmp_out) begin
              int_status_reg[1] <= 1'b1;
              if (compare_brake_enable) begin
                fault_brake_reg   <= 1'b1;
                pwm_run_clear_reg <= 1'b1;
              end
            end
          end else begin
            compare_result_flag <= 1'b0;
          end
        end else begin
          conv_cnt_reg <= conv_cnt_reg - `CONV_ONE;
        end
      end
      // Brake released when brake disabled, comparator off or compare flag clear
      // Release lags the flag by one cycle
      if (fault_brake_reg && (!compare_brake_enable || !comparator_enable || !compare_result_flag))
        fault_brake_reg <= 1'b0;
      // Read data and read-to-clear of status; new events win
      if (rd) begin
        case (addr)
          `ADDR_CTRL_ONE:    rdata_reg <= {4'h0, ext_trigger_type, ext_trigger_enable, converter_on};
          `ADDR_CTRL_TWO:    rdata_reg <= {compare_brake_enable, compare_polarity, comparator_enable,
                                           compare_result_flag, 3'h0, trigger_delay_count[8]};
          `ADDR_DELAY_LOW:   rdata_reg <= trigger_delay_count[7:0];
          `ADDR_CTRL_ZERO:   rdata_reg <= {conversion_done_flag, busy_reg, ext_trigger_source, 4'h0};
          `ADDR_THRESH_LOW:  rdata_reg <= compare_threshold[7:0];
          `ADDR_THRESH_HIGH: rdata_reg <= {4'h0, compare_threshold[11:8]};
          `ADDR_INT_STATUS: begin
            rdata_reg <= {6'h00, int_status_reg};
            if (!(busy_reg && (conv_complete || conv_cnt_reg == `CONV_ONE)))
              int_status_reg <= 2'h0;
          end
          `ADDR_INT_MASK:    rdata_reg <= {6'h00, int_mask_reg};
          default:           rdata_reg <= `BYTE_ZERO;
        endcase
      end else begin
        rdata_reg <= `BYTE_ZERO;
      end
      // Interrupt level, one cycle behind status
      irq_reg <= |(int_status_reg & int_mask_reg);
    end
  end
endmodule // adc_trigger_compare_ctrl

// ### verif/adc_trig_sva.sv
// Port assertions for the converter trigger and compare control
`timescale 1ns/10ps
module adc_trig_sva (
  // Clock and reset
  input wire       mclk,
  input wire       srst,
  // Register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata_reg,
  // Converter, brake and interrupt
  input wire       converter_on_reg,
  input wire       conv_start_reg,
  input wire       fault_brake_reg,
  input wire       pwm_run_clear_reg,
  input wire       irq_reg
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // Outputs, start pulses and brake
  a_reset_quiet: assert property ($fell(srst) |-> !(converter_on_reg | conv_start_reg | fault_brake_reg | irq_reg))
    else $error("output set after reset");
  a_start_single: assert property (conv_start_reg |=> !conv_start_reg [*2])
    else $error("start repeated");
  a_on_follows: assert property (wr && addr == 8'he1 |-> ##2 converter_on_reg == $past(wdata[0], 2))
    else $error("enable not followed");
  a_off_no_start: assert property (!converter_on_reg [*3] |-> !conv_start_reg)
    else $error("start while off");
  a_busy_reads: assert property (conv_start_reg ##1 (rd && addr == 8'he8) |=> rdata_reg[6])
    else $error("busy not read");
  a_clear_pulse: assert property (pwm_run_clear_reg |=> !pwm_run_clear_reg)
    else $error("run clear too long");
  a_clear_brake: assert property (pwm_run_clear_reg |-> fault_brake_reg)
    else $error("run clear without brake");
  a_brake_rise: assert property ($rose(fault_brake_reg) |-> pwm_run_clear_reg)
    else $error("brake without run clear");
endmodule // adc_trig_sva

bind adc_trigger_compare_ctrl adc_trig_sva i_sva (.mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata_reg(rdata_reg), .converter_on_reg(converter_on_reg), .conv_start_reg(conv_start_reg),
  .fault_brake_reg(fault_brake_reg), .pwm_run_clear_reg(pwm_run_clear_reg), .irq_reg(irq_reg));

// ### verif/pwm_far_model.sv
// Far-side model: PWM channel lines, start pin and period events
`timescale 1ns/10ps
module pwm_far_model (
  // Clock
  input wire       mclk,
  // Event request
  input wire [2:0] ev_sel,
  input wire       ev_go,
  // Source lines and period events
  output reg [3:0] src_lines,
  output reg       period_centre,
  output reg       period_end
);
  // Quiet lines at time zero
  initial begin
    src_lines = 4'h0;
    period_centre = 1'b0;
    period_end = 1'b0;
  end
  // Toggle one line or pulse one period event per request
  always @(posedge mclk) begin
    period_centre <= ev_go && ev_sel == 3'h4;
    period_end <= ev_go && ev_sel == 3'h5;
    if (ev_go && !ev_sel[2]) src_lines[ev_sel[1:0]] <= !src_lines[ev_sel[1:0]];
  end
endmodule // pwm_far_model

// ### verif/adc_trigger_compare_ctrl_test.sv
// Self-checking bench for the converter trigger and compare control
`timescale 1ns/10ps
module adc_trigger_compare_ctrl_test;
  reg         mclk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, conv_complete = 1'b0;
  reg         centre_mode = 1'b0, ev_go = 1'b0, fx;
  reg  [7:0]  addr = 8'h00, wdata = 8'h00, e8v = 8'h30, cfg;
  reg  [11:0] result = 12'h000;
  reg  [2:0]  ev_sel = 3'h0;
  wire [7:0]  rdata_reg;
  wire [3:0]  src_lines;
  wire        period_centre, period_end, converter_on_reg, conv_start_reg, fault_brake_reg, pwm_run_clear_reg, irq_reg;
  integer     n_errors = 0, cmp_count = 0, n_clr = 0, lat, l1, i, s;

  // Clock and run-clear pulse count
  initial forever #5 mclk = !mclk;
  always @(posedge mclk) if (pwm_run_clear_reg === 1'b1) n_clr <= n_clr + 1;

  adc_trigger_compare_ctrl i_dut (.mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_reg(rdata_reg), .pwm_channel_zero(src_lines[0]), .pwm_channel_two(src_lines[1]),
    .pwm_channel_four(src_lines[2]), .ext_start_pin(src_lines[3]), .pwm_centre_aligned(centre_mode),
    .pwm_period_centre(period_centre), .pwm_period_end(period_end), .conversion_result(result),
    .conv_complete(conv_complete), .converter_on_reg(converter_on_reg), .conv_start_reg(conv_start_reg),
    .fault_brake_reg(fault_brake_reg), .pwm_run_clear_reg(pwm_run_clear_reg), .irq_reg(irq_reg));
  pwm_far_model i_far (.mclk(mclk), .ev_sel(ev_sel), .ev_go(ev_go), .src_lines(src_lines),
    .period_centre(period_centre), .period_end(period_end));

  // Verdict
  task close_out;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk_val(input [15:0] got, input [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Register port cycles
  task wr_reg(input [7:0] a, input [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task rd_chk(input [7:0] a, input [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk_val(rdata_reg, exp);
  endtask
  // Conversion helpers
  task wait_start(input integer lim);
    lat = 0;
    while (conv_start_reg !== 1'b1 && lat < lim) begin
      @(posedge mclk);
      lat++;
    end
  endtask
  task finish_conv(input [11:0] r);
    result <= r;
    conv_complete <= 1'b1;
    @(posedge mclk);
    conv_complete <= 1'b0;
    @(posedge mclk);
  endtask
  task pulse_ev(input [2:0] sel);
    @(posedge mclk);
    ev_sel <= sel;
    ev_go <= 1'b1;
    @(posedge mclk);
    ev_go <= 1'b0;
  endtask
  task trig(input [2:0] sel, input want);
    pulse_ev(sel);
    wait_start(300);
    chk_val(lat < 300, want);
    if (lat < 300) begin
      finish_conv(12'h000);
      wr_reg(8'he8, e8v);
    end
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    wr_reg(8'he9, 8'hff);
    for (i = 0; i < 10; i++) rd_chk(8'he0 + i[7:0], 8'h00);
    wr_reg(8'he1, 8'h01);
    wr_reg(8'he8, e8v);
    trig(3'h3, 1'b0);
    trig(3'h3, 1'b0);
    wr_reg(8'he1, 8'h00);
    wr_reg(8'he8, 8'h70);
    wait_start(20);
    chk_val(lat, 20);
    for (s = 0; s < 4; s++) begin
      e8v = {2'b00, s[1:0], 4'h0};
      wr_reg(8'he8, e8v);
      wr_reg(8'he1, 8'h03);
      trig(s[2:0], 1'b0);
      trig(s[2:0], 1'b1);
      wr_reg(8'he1, 8'h07);
      trig(s[2:0], 1'b1);
      trig(s[2:0], 1'b0);
    end
    // Software start with delay set, event while busy
    wr_reg(8'he3, 8'h05);
    wr_reg(8'he2, 8'h01);
    wr_reg(8'he7, 8'h01);
    wr_reg(8'he8, 8'h70);
    wait_start(20);
    chk_val(lat, 1);
    pulse_ev(3'h3);
    rd_chk(8'he8, 8'h70);
    repeat (4) @(posedge mclk);
    finish_conv(12'h000);
    rd_chk(8'he8, 8'hb0);
    chk_val(irq_reg, 1);
    rd_chk(8'he6, 8'h01);
    @(posedge mclk);
    #1 chk_val(irq_reg, 0);
    wr_reg(8'he8, 8'hf0);
    wait_start(20);
    chk_val(lat, 20);
    wr_reg(8'he8, e8v);
    wait_start(300);
    chk_val(lat, 300);
    // Delay of 0x105 against none
    trig(3'h3, 1'b0);
    trig(3'h3, 1'b1);
    l1 = lat;
    wr_reg(8'he3, 8'h00);
    wr_reg(8'he2, 8'h00);
    trig(3'h3, 1'b0);
    trig(3'h3, 1'b1);
    chk_val(l1 - lat, 261);
    // Period events
    wr_reg(8'he1, 8'h0b);
    trig(3'h4, 1'b0);
    centre_mode <= 1'b1;
    trig(3'h4, 1'b1);
    trig(3'h5, 1'b0);
    wr_reg(8'he1, 8'h0f);
    trig(3'h5, 1'b1);
    // Compare polarity, enable and brake
    wr_reg(8'he7, 8'h00);
    wr_reg(8'he5, 8'h08);
    for (i = 0; i < 5; i++) begin
      fx = (i[1] == i[0]) && !i[2];
      cfg = {1'b1, i[1], !i[2], 5'h00};
      wr_reg(8'he2, cfg);
      wr_reg(8'he8, e8v | 8'h40);
      wait_start(20);
      finish_conv(i[0] ? 12'h7ff : 12'h800);
      #1;
      chk_val(fault_brake_reg, fx);
      if (i < 4) rd_chk(8'he2, cfg | {3'h0, fx, 4'h0});
      chk_val(irq_reg, 0);
      wr_reg(8'he8, e8v);
    end
    chk_val(n_clr, 2);
    close_out;
  end
  // Watchdog
  initial begin
    #400000;
    n_errors++;
    close_out;
  end
endmodule // adc_trigger_compare_ctrl_test
